/* File: src/rbs_pkg.sv */
// Package: constants and types for the reset and brown-out sequencer
package rbs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned POWER_UP_TIMER_MS          = 64;
  localparam int unsigned POWER_UP_TIMER_CYCLES      = (CLK_HZ / 1000) * POWER_UP_TIMER_MS;
  localparam int unsigned FILTER_NS        = 1000;
  localparam int unsigned FILTER_CYCLES    = (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W            = 32;

  // ****************************************
  // Brown-out mode field encodings
  // ****************************************
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_SW    = 2'h1;
  localparam logic [1:0] MODE_NOSLP = 2'h2;
  localparam logic [1:0] MODE_ON    = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic SW_EN_RST = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RBS_HOLD  = 2'b00,
    RBS_TIMER = 2'b01,
    RBS_WAIT  = 2'b11,
    RBS_RUN   = 2'b10
  } rbs_state_t;

  typedef struct packed {
    logic por;
    logic brownout;
    logic lp_brownout;
    logic clear_pin;
    logic watchdog;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic prog_exit;
  } rbs_src_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       level;
    logic       power_up_timer_en_n;
    logic       clear_pin_en;
    logic       stack_rst_en;
  } rbs_cfg_t;

endpackage : rbs_pkg

/* File: src/rbs_filter.sv */
// Glitch filter: output follows input only after it has held for LEN cycles
`timescale 1ns/1ps
`default_nettype none

module rbs_filter #(
  parameter int unsigned LEN = 1
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // Data
  input  wire logic raw_i,
  output logic      filt_o
);

  logic [31:0] cnt_q;
  logic        hold_q;
  wire         differ = (raw_i != hold_q);
  wire         done   = (cnt_q >= LEN - 1);

  // Count while input differs from held value
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= 32'h0;
      hold_q <= 1'b0;
    end else if (ce_i) begin
      if (!differ) begin
        cnt_q <= 32'h0;
      end else if (done) begin
        cnt_q  <= 32'h0;
        hold_q <= raw_i;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign filt_o = hold_q;

endmodule // rbs_filter

`default_nettype wire

/* File: src/rbs_top.sv */
// Reset and brown-out sequencer: collects reset sources, times start-up
`timescale 1ns/1ps
`default_nettype none

module rbs_top #(
  parameter int unsigned POWER_UP_TIMER_CYC = rbs_pkg::POWER_UP_TIMER_CYCLES
) (
  // Clock, reset, enable
  input  wire logic             CLK_SYS_I,
  input  wire logic             NRST_I,
  input  wire logic             CE_I,
  // Analog detectors and reset sources (asynchronous)
  input  wire logic             SUPPLY_OK_I,
  input  wire logic             BELOW_HI_I,
  input  wire logic             BELOW_LO_I,
  input  wire logic             MON_READY_I,
  input  wire logic             LP_BROWNOUT_I,
  input  wire logic             CLEAR_PIN_N_I,
  input  wire logic             OSC_READY_I,
  // Core-side reset requests and Sleep status (same clock)
  input  wire logic             WATCHDOG_I,
  input  wire logic             RESET_INSTR_I,
  input  wire logic             STACK_OVER_I,
  input  wire logic             STACK_UNDER_I,
  input  wire logic             PROG_EXIT_I,
  input  wire logic             SLEEP_I,
  // Configuration
  input  wire rbs_pkg::rbs_cfg_t CFG_I,
  input  wire logic             SW_EN_WR_I,
  input  wire logic             SW_EN_WDATA_I,
  // Outputs
  output logic                  MON_ENABLE_O,
  output logic                  LEVEL_SEL_O,
  output logic                  SW_EN_O,
  output logic                  READY_O,
  output logic                  CORE_RESET_O,
  output logic                  WAKE_HOLD_O,
  output rbs_pkg::rbs_src_t     CAUSE_O
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NS = 7;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  wire  [NS-1:0] raw = {SUPPLY_OK_I, BELOW_HI_I, BELOW_LO_I, MON_READY_I,
                        LP_BROWNOUT_I, CLEAR_PIN_N_I, OSC_READY_I};

  // Two flops on every asynchronous input
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (CE_I) begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  wire supply_ok = s2_q[6];
  wire below_hi  = s2_q[5];
  wire below_lo  = s2_q[4];
  wire mon_rdy   = s2_q[3];
  wire lp_bor    = s2_q[2];
  wire pin_n     = s2_q[1];
  wire osc_rdy   = s2_q[0];

  // ****************************************
  // Brown-out monitor control
  // ****************************************
  logic sw_en_q;

  // Software enable bit: always writable
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sw_en_q <= rbs_pkg::SW_EN_RST;
    end else if (CE_I && SW_EN_WR_I) begin
      sw_en_q <= SW_EN_WDATA_I;
    end
  end

  wire [1:0] mode    = CFG_I.mode;
  wire m_on    = (mode == rbs_pkg::MODE_ON);
  wire m_noslp = (mode == rbs_pkg::MODE_NOSLP);
  wire m_sw    = (mode == rbs_pkg::MODE_SW);
  // Monitor enable per mode
  wire mon_en  = m_on | (m_noslp & ~SLEEP_I) | (m_sw & sw_en_q);
  // Trip level chosen by config bit
  wire below   = CFG_I.level ? below_hi : below_lo;
  // Protection only once monitor ready
  wire trip_raw = mon_en & mon_rdy & below;
  wire trip_filt;

  rbs_filter #(
    .LEN (rbs_pkg::FILTER_CYCLES)
  ) u_filter (
    .clk_i  (CLK_SYS_I),
    .nrst_i (NRST_I),
    .ce_i   (CE_I),
    .raw_i  (trip_raw),
    .filt_o (trip_filt)
  );

  // Combined brown-out request
  wire bor_req = trip_filt | lp_bor;
  // Power-on request, includes programming-mode exit
  wire por_req = ~supply_ok | PROG_EXIT_I;
  // Start-up waits for ready and supply in forced modes
  wire bor_wait = (m_on | m_noslp) & (~mon_rdy | below);
  // Clear pin active when enabled
  wire pin_rst  = CFG_I.clear_pin_en & ~pin_n;
  // Other resets
  wire stk_rst  = CFG_I.stack_rst_en & (STACK_OVER_I | STACK_UNDER_I);
  wire misc_rst = WATCHDOG_I | RESET_INSTR_I | stk_rst;

  // ****************************************
  // Start-up sequence
  // ****************************************
  rbs_pkg::rbs_state_t st_q;
  rbs_pkg::rbs_state_t st_d;
  logic [rbs_pkg::CNT_W-1:0] cnt_q;
  wire  timer_done = (cnt_q >= POWER_UP_TIMER_CYC - 1);

  // Next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      rbs_pkg::RBS_HOLD: begin
        // Timer waits for both releases
        if (!por_req && !bor_req) begin
          st_d = CFG_I.power_up_timer_en_n ? rbs_pkg::RBS_WAIT : rbs_pkg::RBS_TIMER;
        end
      end
      rbs_pkg::RBS_TIMER: begin
        if (por_req || bor_req) begin
          st_d = rbs_pkg::RBS_HOLD;
        end else if (timer_done) begin
          st_d = rbs_pkg::RBS_WAIT;
        end
      end
      rbs_pkg::RBS_WAIT: begin
        if (por_req || bor_req) begin
          st_d = rbs_pkg::RBS_HOLD;
        end else if (osc_rdy && !bor_wait) begin
          st_d = rbs_pkg::RBS_RUN;
        end
      end
      rbs_pkg::RBS_RUN: begin
        if (por_req || bor_req) begin
          st_d = rbs_pkg::RBS_HOLD;
        end
      end
      default: st_d = rbs_pkg::RBS_HOLD;
    endcase
  end

  // State and power-up counter
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q  <= rbs_pkg::RBS_HOLD;
      cnt_q <= '0;
    end else if (CE_I) begin
      st_q  <= st_d;
      cnt_q <= (st_q == rbs_pkg::RBS_TIMER) ? cnt_q + 32'h1 : '0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic              core_rst_q;
  logic              wake_q;
  rbs_pkg::rbs_src_t cause_q;
  rbs_pkg::rbs_src_t cause_d;

  // Reset cause capture
  always_comb begin
    cause_d             = '0;
    cause_d.por         = por_req & ~PROG_EXIT_I;
    cause_d.brownout    = trip_filt;
    cause_d.lp_brownout = lp_bor;
    cause_d.clear_pin   = pin_rst;
    cause_d.watchdog    = WATCHDOG_I;
    cause_d.reset_instr = RESET_INSTR_I;
    cause_d.stack_over  = CFG_I.stack_rst_en & STACK_OVER_I;
    cause_d.stack_under = CFG_I.stack_rst_en & STACK_UNDER_I;
    cause_d.prog_exit   = PROG_EXIT_I;
  end

  wire hold_core = (st_q != rbs_pkg::RBS_RUN) | pin_rst | misc_rst;

  // Registered core reset, wake hold and cause
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      core_rst_q <= 1'b1;
      wake_q     <= 1'b0;
      cause_q    <= '0;
    end else if (CE_I) begin
      core_rst_q <= hold_core;
      // Wake delay only in off-in-Sleep mode
      wake_q     <= m_noslp & ~mon_rdy;
      if (|cause_d) begin
        cause_q <= cause_d;
      end
    end
  end

  assign MON_ENABLE_O = mon_en;
  assign LEVEL_SEL_O  = CFG_I.level;
  assign SW_EN_O      = sw_en_q;
  assign READY_O      = mon_rdy & mon_en;
  assign CORE_RESET_O = core_rst_q;
  assign WAKE_HOLD_O  = wake_q;
  assign CAUSE_O      = cause_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_released;
    !por_req && !bor_req;
  endsequence

  a_timer_holds: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (st_q == rbs_pkg::RBS_TIMER) |=> CORE_RESET_O)
    else $error("core left reset while timer ran");
  a_timer_start: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (CE_I && st_q == rbs_pkg::RBS_HOLD && !CFG_I.power_up_timer_en_n) ##0 s_released
    |=> st_q == rbs_pkg::RBS_TIMER)
    else $error("power-up timer did not start");
  a_bypass_timer: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    CFG_I.power_up_timer_en_n |-> st_q != rbs_pkg::RBS_TIMER || $past(!CFG_I.power_up_timer_en_n))
    else $error("timer ran while bypassed");
  a_por_resets: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (CE_I && por_req) |=> st_q == rbs_pkg::RBS_HOLD ##1 CORE_RESET_O)
    else $error("power-on request did not reset");
  a_wdt_resets: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (CE_I && WATCHDOG_I) |=> CORE_RESET_O)
    else $error("watchdog did not reset core");
  a_lp_bor_or: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    lp_bor |-> bor_req)
    else $error("low-power brown-out not combined");
  a_sw_mode_en: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    m_sw |-> MON_ENABLE_O == sw_en_q)
    else $error("software mode enable mismatch");
  a_off_mode: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (mode == rbs_pkg::MODE_OFF) |-> !MON_ENABLE_O && !bor_wait)
    else $error("monitor active in off mode");
  a_sleep_off: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (m_noslp && SLEEP_I) |-> !trip_raw)
    else $error("protection active in Sleep");

endmodule // rbs_top

`default_nettype wire

/* File: testbench/rbs_analog_model.sv */
// Model of the supply detectors, brown-out monitor and oscillator ready (follows supply_ok_o, no timer)
`timescale 1ns/1ps
`default_nettype none

module rbs_analog_model #(
  parameter int POR_MV  = 1600,
  parameter int HI_MV   = 2700,
  parameter int LO_MV   = 2400,
  parameter int RDY_DLY = 8
) (
  // Clock and monitor control
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic block_i,
  input  var  int   vdd_mv_i,
  // Detector outputs
  output logic      supply_ok_o,
  output logic      below_hi_o,
  output logic      below_lo_o,
  output logic      ready_o,
  output logic      osc_ready_o
);
  int cnt;

  // Comparators follow the supply level
  assign supply_ok_o = (vdd_mv_i >= POR_MV);
  assign below_hi_o  = (vdd_mv_i < HI_MV);
  assign below_lo_o  = (vdd_mv_i < LO_MV);
  assign osc_ready_o = supply_ok_o;
  assign ready_o     = (cnt >= RDY_DLY);

  // Monitor settles only while enabled and not blocked; drops ready at the next clock edge when off or blocked
  always @(posedge clk_i) begin
    cnt <= (en_i && !block_i) ? ((cnt < RDY_DLY) ? cnt + 1 : cnt) : 0;
  end
endmodule // rbs_analog_model

`default_nettype wire

/* File: testbench/rbs_top_tb.sv */
// Self-checking testbench of the reset and brown-out sequencer
`timescale 1ns/1ps
`default_nettype none

module rbs_top_tb;
  logic              clk = 0, nrst = 0, sleep = 0, lp = 0, clr_n = 1;
  logic              wr = 0, wdata = 0, block = 0;
  logic [4:0]        req = '0;
  int                fail_count = 0, n_tests = 0, cyc = 0, vdd = 3300, k;
  rbs_pkg::rbs_cfg_t cfg = '{2'h0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic              mon_en, lvl, sw_en, rdy, core_rst, wake_hold;
  logic              s_ok, b_hi, b_lo, m_rdy, o_rdy;
  rbs_pkg::rbs_src_t cause;

  rbs_top #(.POWER_UP_TIMER_CYC(20)) rbs_top_inst (
    .CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(1'b1), .SUPPLY_OK_I(s_ok),
    .BELOW_HI_I(b_hi), .BELOW_LO_I(b_lo), .MON_READY_I(m_rdy),
    .LP_BROWNOUT_I(lp), .CLEAR_PIN_N_I(clr_n), .OSC_READY_I(o_rdy),
    .WATCHDOG_I(req[4]), .RESET_INSTR_I(req[3]), .STACK_OVER_I(req[2]),
    .STACK_UNDER_I(req[1]), .PROG_EXIT_I(req[0]), .SLEEP_I(sleep), .CFG_I(cfg),
    .SW_EN_WR_I(wr), .SW_EN_WDATA_I(wdata), .MON_ENABLE_O(mon_en),
    .LEVEL_SEL_O(lvl), .SW_EN_O(sw_en), .READY_O(rdy), .CORE_RESET_O(core_rst),
    .WAKE_HOLD_O(wake_hold), .CAUSE_O(cause));

  rbs_analog_model rbs_analog_model_inst (
    .clk_i(clk), .en_i(mon_en), .block_i(block), .vdd_mv_i(vdd),
    .supply_ok_o(s_ok), .below_hi_o(b_hi), .below_lo_o(b_lo),
    .ready_o(m_rdy), .osc_ready_o(o_rdy));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      $display("Error %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  // Bounded wait for the core reset level, then compare
  task automatic wait_rst(input logic lvl_e, input int max);
    for (k = 0; k < max && core_rst !== lvl_e; k++) tick(1);
    chk(core_rst, lvl_e);
  endtask

  // Restart under a new configuration
  task automatic boot(input logic [1:0] mode, input logic power_up_timer_n);
    nrst = 0;
    cfg = '{mode, 1'b0, power_up_timer_n, 1'b1, 1'b1};
    tick(2);
    nrst = 1;
  endtask

  task automatic sw_write(input logic v);
    wr = 1;
    wdata = v;
    tick(1);
    wr = 0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tick(16);
    nrst = 1;
    tick(22);
    chk(core_rst, 1);
    wait_rst(0, 30);
    chk(sw_en, rbs_pkg::SW_EN_RST);
    // Core-side sources, bit i of req matches bit i of the cause
    for (int i = 0; i < 5; i++) begin
      req[i] = 1;
      tick(1);
      req = '0;
      wait_rst(1, 3);
      chk(cause[i], 1);
      if (i == 0) begin
        tick(15);
        chk(core_rst, 1);
      end
      wait_rst(0, 40);
    end
    cfg.stack_rst_en = 0;
    req[2] = 1;
    tick(1);
    req = '0;
    tick(4);
    chk(core_rst, 0);
    // Clear pin outlasting the timers
    clr_n = 0;
    wait_rst(1, 8);
    chk(cause.clear_pin, 1);
    tick(30);
    clr_n = 1;
    wait_rst(0, 10);
    lp = 1;
    wait_rst(1, 8);
    chk(cause.lp_brownout, 1);
    lp = 0;
    wait_rst(0, 40);
    // Supply below power-on level
    vdd = 1000;
    boot(rbs_pkg::MODE_OFF, 0);
    tick(60);
    chk(core_rst, 1);
    chk(cause.por, 1);
    vdd = 3300;
    tick(22);
    chk(core_rst, 1);
    wait_rst(0, 30);
    // Monitor off: dips ignored, timer bypassed
    boot(rbs_pkg::MODE_OFF, 1);
    wait_rst(0, 12);
    chk(mon_en, 0);
    vdd = 2000;
    tick(60);
    chk(core_rst, 0);
    vdd = 3300;
    cfg.level = 1;
    tick(1);
    chk(lvl, 1);
    // Always on: waits for ready, filters dips
    block = 1;
    boot(rbs_pkg::MODE_ON, 1);
    tick(30);
    chk(core_rst, 1);
    block = 0;
    wait_rst(0, 20);
    vdd = 2000;
    tick(20);
    vdd = 3300;
    tick(10);
    chk(core_rst, 0);
    vdd = 2000;
    tick(30);
    chk(core_rst, 0);
    wait_rst(1, 20);
    chk(cause.brownout, 1);
    vdd = 3300;
    wait_rst(0, 60);
    sw_write(0);
    tick(2);
    chk(sw_en, 0);
    chk(mon_en, 1);
    sleep = 1;
    tick(4);
    chk(mon_en, 1);
    chk(wake_hold, 0);
    vdd = 2000;
    wait_rst(1, 50);
    vdd = 3300;
    sleep = 0;
    wait_rst(0, 60);
    // Off in Sleep
    block = 1;
    boot(rbs_pkg::MODE_NOSLP, 1);
    tick(30);
    chk(core_rst, 1);
    block = 0;
    wait_rst(0, 20);
    sleep = 1;
    tick(4);
    chk(mon_en, 0);
    vdd = 2000;
    tick(60);
    chk(core_rst, 0);
    vdd = 3300;
    sleep = 0;
    tick(3);
    chk(wake_hold, 1);
    tick(20);
    chk(wake_hold, 0);
    // Software controlled
    block = 1;
    boot(rbs_pkg::MODE_SW, 1);
    wait_rst(0, 15);
    chk(rdy, 0);
    block = 0;
    tick(12);
    chk(rdy, 1);
    sleep = 1;
    tick(3);
    chk(mon_en, 1);
    sleep = 0;
    sw_write(0);
    tick(2);
    chk(sw_en, 0);
    chk(mon_en, 0);
    vdd = 2000;
    tick(60);
    chk(core_rst, 0);
    complete_run();
  end
endmodule // rbs_top_tb

`default_nettype wire
